// ---- rtl/drt_map.svh ----
/*
 * Constants for the refresh cycle timing block: timing word field layout,
 * reset value and clock counts.
 * Assumes inclusion by its bare name from the design file and the bench.
 */
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH

// Timing word layout
`define DRT_RSVD_HI 24
`define DRT_RSVD_LO 15
`define DRT_RFC_HI 14
`define DRT_RFC_LO 12
`define DRT_TIMING_RESET 32'h0000_0000

// Refresh cycle time decode: code 0 is the longest, never below the floor
`define DRT_RFC_BASE 4'he
`define DRT_RFC_FLOOR 4'h8

// Default row cycle time and read turnaround in clocks; burst length in beats, two per clock
`define DRT_RC_CLOCKS 4
`define DRT_BURST_LEN 4
`define DRT_RD_TURN 1

`endif

// ---- rtl/drt_pkg.sv ----
/*
 * Types of the refresh cycle timing block.
 * Assumes drt_map.svh holds the numeric constants.
 */
`default_nettype none
package drt_pkg;

    typedef enum logic [2:0] {
        DRT_CMD_NOP = 3'h0,
        DRT_CMD_ACT = 3'h1,
        DRT_CMD_RD  = 3'h2,
        DRT_CMD_WR  = 3'h3,
        DRT_CMD_PRE = 3'h4,
        DRT_CMD_REF = 3'h5
    } drt_cmd_e;

    typedef struct packed {
        drt_cmd_e cmd;
        logic [1:0] row;
    } drt_req_s;

endpackage

`default_nettype wire

// ---- rtl/drt_refresh_timing.sv ----
/*
 * Command timing gate of a DDR SDRAM controller: holds back activates after
 * refresh or activate of the same row, and spaces back-to-back reads.
 * Assumes the scheduler presents one command at a time and issues it only in
 * the cycle in which grant is high; clk is 250 MHz, rst synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "drt_map.svh"

module drt_refresh_timing #(
    parameter int ROWS = 4,
    parameter int CNT_W = 4,
    parameter logic [CNT_W-1:0] RC_CLOCKS = CNT_W'(`DRT_RC_CLOCKS),
    parameter int BURST_LEN = `DRT_BURST_LEN,
    parameter int RD_TURN = `DRT_RD_TURN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timing configuration word and its readback
    input wire logic [31:0] timing_word,
    output logic [31:0] timing_rdback,
    output logic [3:0] refresh_cycle_time,
    // Command request from the scheduler
    input wire logic req_valid,
    input wire drt_pkg::drt_req_s req,
    output logic grant,
    // Per-row activate permission
    output logic [ROWS-1:0] act_ready
);

    localparam logic [CNT_W-1:0] RD_SPACE = CNT_W'(BURST_LEN / 2 + RD_TURN);

    // Clocks between refresh and activate for a field code
    function automatic logic [3:0] rfc_clocks(input logic [2:0] code);
        logic [3:0] raw;
        raw = 4'(`DRT_RFC_BASE - {1'b0, code});
        rfc_clocks = (raw < `DRT_RFC_FLOOR) ? `DRT_RFC_FLOOR : raw;
    endfunction

    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == '0) ? v : CNT_W'(v - 1'b1);
    endfunction

    logic [31:0] timing_reg;
    logic [31:0] timing_next;
    logic [3:0] rfc_reg;
    logic [3:0] rfc_next;
    logic [CNT_W-1:0] ref_tmr_reg [ROWS];
    logic [CNT_W-1:0] ref_tmr_next [ROWS];
    logic [CNT_W-1:0] rc_tmr_reg [ROWS];
    logic [CNT_W-1:0] rc_tmr_next [ROWS];
    logic [CNT_W-1:0] rd_tmr_reg;
    logic [CNT_W-1:0] rd_tmr_next;
    logic [1:0] last_rd_row_reg;
    logic [1:0] last_rd_row_next;
    logic allowed;

    // Configuration capture; reserved bits never reach any logic
    always_comb begin
        timing_next = timing_word;
        timing_next[`DRT_RSVD_HI:`DRT_RSVD_LO] = '0;
        rfc_next = rfc_clocks(timing_word[`DRT_RFC_HI:`DRT_RFC_LO]);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timing_reg <= `DRT_TIMING_RESET;
            rfc_reg <= `DRT_RFC_BASE;
        end else begin
            timing_reg <= timing_next;
            rfc_reg <= rfc_next;
        end
    end

    assign timing_rdback = timing_reg;
    assign refresh_cycle_time = rfc_reg;

    // Permission for the presented command
    always_comb begin
        for (int r = 0; r < ROWS; r++) begin
            act_ready[r] = (ref_tmr_reg[r] == '0) && (rc_tmr_reg[r] == '0);
        end
        case (req.cmd)
            drt_pkg::DRT_CMD_ACT: allowed = act_ready[req.row];
            drt_pkg::DRT_CMD_RD: allowed = (rd_tmr_reg == '0);
            default: allowed = 1'b1;
        endcase
        grant = req_valid && allowed;
    end

    // Timers count down; a timer loaded with N-1 frees the command N clocks later
    always_comb begin
        rd_tmr_next = dec_sat(rd_tmr_reg);
        last_rd_row_next = last_rd_row_reg;
        for (int r = 0; r < ROWS; r++) begin
            ref_tmr_next[r] = dec_sat(ref_tmr_reg[r]);
            rc_tmr_next[r] = dec_sat(rc_tmr_reg[r]);
        end
        if (grant) begin
            case (req.cmd)
                drt_pkg::DRT_CMD_REF: begin
                    ref_tmr_next[req.row] = CNT_W'(rfc_reg - 4'h1);
                end
                drt_pkg::DRT_CMD_ACT: begin
                    rc_tmr_next[req.row] = CNT_W'(RC_CLOCKS - 1'b1);
                end
                drt_pkg::DRT_CMD_RD: begin
                    // A read to another row does not cut the burst short
                    rd_tmr_next = CNT_W'(RD_SPACE - 1'b1);
                    last_rd_row_next = req.row;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_tmr_reg <= '0;
            last_rd_row_reg <= 2'h0;
            for (int r = 0; r < ROWS; r++) begin
                ref_tmr_reg[r] <= '0;
                rc_tmr_reg[r] <= '0;
            end
        end else begin
            rd_tmr_reg <= rd_tmr_next;
            last_rd_row_reg <= last_rd_row_next;
            for (int r = 0; r < ROWS; r++) begin
                ref_tmr_reg[r] <= ref_tmr_next[r];
                rc_tmr_reg[r] <= rc_tmr_next[r];
            end
        end
    end

    // Helper: clocks since the last read grant, saturating
    logic [3:0] since_rd_reg;
    logic [3:0] since_rd_next;

    always_comb begin
        since_rd_next = since_rd_reg;
        if (grant && req.cmd == drt_pkg::DRT_CMD_RD) begin
            since_rd_next = 4'h1;
        end else if (since_rd_reg != 4'hf) begin
            since_rd_next = since_rd_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            since_rd_reg <= 4'hf;
        end else begin
            since_rd_reg <= since_rd_next;
        end
    end

    chk_rsvd_zero: assert property (
        @(posedge clk) disable iff (rst)
        ##1 timing_rdback[24:15] == 10'h000)
        else $error("reserved timing bits read back non-zero");

    chk_rfc_low_codes: assert property (
        @(posedge clk) disable iff (rst)
        timing_word[14:12] == 3'h1 |=> refresh_cycle_time == 4'hd)
        else $error("code 001 does not give 13 clocks");

    chk_rfc_floor: assert property (
        @(posedge clk) disable iff (rst)
        timing_word[14] |=> refresh_cycle_time >= 4'h8 && refresh_cycle_time <= 4'ha)
        else $error("upper refresh codes out of range");

    chk_rfc_code_three: assert property (
        @(posedge clk) disable iff (rst)
        timing_word[14:12] == 3'h3 |=> refresh_cycle_time == 4'hb)
        else $error("code 011 does not give 11 clocks");

    chk_rd_spacing: assert property (
        @(posedge clk) disable iff (rst)
        grant && req.cmd == drt_pkg::DRT_CMD_RD |-> since_rd_reg >= 4'(RD_SPACE))
        else $error("reads closer than burst spacing");

    chk_rd_block: assert property (
        @(posedge clk) disable iff (rst)
        grant && req.cmd == drt_pkg::DRT_CMD_RD |=> !grant || req.cmd != drt_pkg::DRT_CMD_RD)
        else $error("back-to-back read granted");

    // A read to another row still waits out the whole burst
    chk_rd_other_row: assert property (
        @(posedge clk) disable iff (rst)
        grant && req.cmd == drt_pkg::DRT_CMD_RD && req.row != last_rd_row_reg
        |-> since_rd_reg >= 4'(`DRT_BURST_LEN / 2 + `DRT_RD_TURN))
        else $error("read to another row cut the burst short");

    for (genvar g = 0; g < ROWS; g++) begin : g_chk
        chk_ref_load: assert property (
            @(posedge clk) disable iff (rst)
            grant && req.cmd == drt_pkg::DRT_CMD_REF && req.row == g
            |=> ref_tmr_reg[g] == CNT_W'($past(rfc_reg) - 4'h1))
            else $error("refresh timer not loaded with cycle time");

        chk_ref_hold: assert property (
            @(posedge clk) disable iff (rst)
            grant && req.cmd == drt_pkg::DRT_CMD_REF && req.row == g && rfc_reg == 4'he
            |=> !act_ready[g] [*8])
            else $error("activate allowed too soon after refresh");

        chk_timers_apart: assert property (
            @(posedge clk) disable iff (rst)
            grant && req.cmd == drt_pkg::DRT_CMD_ACT && req.row == g
            |-> ref_tmr_reg[g] == '0 && rc_tmr_reg[g] == '0)
            else $error("activate granted with a timer running");

        chk_rc_load: assert property (
            @(posedge clk) disable iff (rst)
            grant && req.cmd == drt_pkg::DRT_CMD_ACT && req.row == g
            |=> rc_tmr_reg[g] == CNT_W'(`DRT_RC_CLOCKS - 1))
            else $error("row cycle timer not loaded on activate");

        chk_ref_keeps_rc: assert property (
            @(posedge clk) disable iff (rst)
            grant && req.cmd == drt_pkg::DRT_CMD_REF && req.row == g && rc_tmr_reg[g] == '0
            |=> rc_tmr_reg[g] == '0)
            else $error("refresh started the row cycle timer");

        chk_act_keeps_ref: assert property (
            @(posedge clk) disable iff (rst)
            grant && req.cmd == drt_pkg::DRT_CMD_ACT && req.row == g
            |=> ref_tmr_reg[g] == '0)
            else $error("activate started the refresh timer");
    end

endmodule // drt_refresh_timing

`default_nettype wire

// ---- test/drt_mem_model.sv ----
/* Memory-side watcher: counts activates issued too soon after a refresh of their row, and reads too soon after a read.
   Assumes issue is high only in cycles where grant was given. */
`timescale 1ns/1ps
`default_nettype none
module drt_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Issued command and the wait that applies
    input wire logic issue,
    input wire drt_pkg::drt_req_s req,
    input wire logic [3:0] t_rfc,
    // Violations seen
    output logic [7:0] errs
);
    int since_ref [4];
    int since_rd;
    always @(posedge clk) begin
        if (rst) begin
            errs <= 8'h00;
            since_rd <= 99;
            foreach (since_ref[k]) since_ref[k] <= 99;
        end else begin
            since_rd <= since_rd + 1;
            foreach (since_ref[k]) since_ref[k] <= since_ref[k] + 1;
            if (issue && req.cmd == drt_pkg::DRT_CMD_REF) since_ref[req.row] <= 1;
            if (issue && req.cmd == drt_pkg::DRT_CMD_ACT && since_ref[req.row] < t_rfc)
                errs <= errs + 8'h01;
            if (issue && req.cmd == drt_pkg::DRT_CMD_RD) begin
                if (since_rd < 3) errs <= errs + 8'h01;
                since_rd <= 1;
            end
        end
    end
endmodule // drt_mem_model
`default_nettype wire

// ---- test/tb_drt_refresh_timing.sv ----
/* Bench for the refresh timing gate: decode table, waits, read spacing.
   Assumes drt_map.svh on the include path and default parameters. */
`timescale 1ns/1ps
`default_nettype none
`include "drt_map.svh"
module tb_drt_refresh_timing;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] timing_word = 32'h0000_0000;
    logic req_valid = 1'b0;
    drt_pkg::drt_req_s req = '0;
    logic [31:0] timing_rdback;
    logic [3:0] refresh_cycle_time;
    logic grant;
    logic [3:0] act_ready;
    logic [3:0] mem_wait = 4'he;
    logic [7:0] errs;
    logic [3:0] exp_tab [8] = '{4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h8};
    int miscompares = 0;
    int samples_checked = 0;
    int w;
    always #2 clk = ~clk;
    drt_refresh_timing u_dut (.clk(clk), .rst(rst), .timing_word(timing_word),
        .timing_rdback(timing_rdback), .refresh_cycle_time(refresh_cycle_time),
        .req_valid(req_valid), .req(req), .grant(grant), .act_ready(act_ready));
    drt_mem_model u_mem (.clk(clk), .rst(rst), .issue(req_valid & grant), .req(req),
        .t_rfc(mem_wait), .errs(errs));
    task automatic close_out();
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Holds the command until granted; w counts refused cycles; valid stays up afterwards
    task automatic send(input drt_pkg::drt_cmd_e c, input logic [1:0] r);
        w = 0;
        req_valid = 1'b1;
        req.cmd = c;
        req.row = r;
        #1;
        while (grant !== 1'b1 && w < 40) begin
            step();
            w++;
        end
        if (w == 40) begin
            miscompares++;
            close_out();
        end
        step();
    endtask
    initial begin
        repeat (16) step();
        rst = 1'b0;
        check(refresh_cycle_time, 32'he);
        check(timing_rdback, 32'h0);
        check(act_ready, 32'hf);
        for (int i = 0; i < 8; i++) begin
            req_valid = 1'b0;
            timing_word = {7'h2e, 10'h3ff, i[2:0], 12'h5a3};
            mem_wait = exp_tab[i];
            step();
            step();
            check(timing_rdback, {7'h2e, 10'h0, i[2:0], 12'h5a3});
            check(refresh_cycle_time, exp_tab[i]);
            send(drt_pkg::DRT_CMD_REF, i[1:0]);
            check(act_ready[i[1:0]], 32'h0);
            send(drt_pkg::DRT_CMD_ACT, i[1:0] + 2'h1);
            check(w, 32'h0);
            send(drt_pkg::DRT_CMD_ACT, i[1:0]);
            check(w, exp_tab[i] - 2);
            $display("code %0d done", i);
        end
        send(drt_pkg::DRT_CMD_ACT, 2'h3);
        check(w, `DRT_RC_CLOCKS - 1);
        send(drt_pkg::DRT_CMD_RD, 2'h0);
        send(drt_pkg::DRT_CMD_RD, 2'h1);
        check(w, `DRT_BURST_LEN / 2 + `DRT_RD_TURN - 1);
        send(drt_pkg::DRT_CMD_PRE, 2'h1);
        check(w, 32'h0);
        $display("spacing done");
        send(drt_pkg::DRT_CMD_REF, 2'h2);
        check(errs, 32'h0);
        req_valid = 1'b0;
        rst = 1'b1;
        step();
        rst = 1'b0;
        check(act_ready, 32'hf);
        check(refresh_cycle_time, 32'he);
        $display("reset done");
        close_out();
    end
endmodule // tb_drt_refresh_timing
`default_nettype wire
